// [core/cps_sequencer.sv]
// Functional notes
// - stay in pre-charge below threshold
// - pre-charge current is one tenth
// - floating threshold pin selects default threshold
// - skip pre-charge if battery already above
// - reaching threshold enters fast charge
// - near regulation voltage enter constant voltage
// - end current filtered before done status
// - below recharge threshold resume charging
// - max timer from fast start, faults
// - pre-charge timer eighth, fault and stop
// - pin high: end current terminates charge
// - pin low: end is fault, continue
// - pin low in pre-charge: default threshold
// - pin falling below 0.5 V resets timer
// - status pins encode charge, done, standby
//
// charge phase sequencer core: comparator results in, status pins out
// assumes comparator inputs are synchronous, already debounced levels
`timescale 1ns/1ps
`include "cps_params.svh"
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int TICK_CYCLES = `CPS_TICK_CYCLES,
  parameter int MAX_TICKS = `CPS_MAX_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // comparators
  input wire logic charge_enable,
  input wire logic bat_above_pre_prog,
  input wire logic bat_above_pre_default,
  input wire logic bat_near_regulation,
  input wire logic bat_below_recharge,
  input wire logic current_below_end,
  input wire logic pin_floating,
  input wire logic pin_above_0v8,
  input wire logic pin_above_0v5,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // charger controls
  output logic charge_on,
  output logic precharge_current,
  output logic cv_mode,
  output logic use_default_threshold,
  // status pins, low enable means pulled low
  output logic status_out_a_o,
  output logic status_out_a_oe_n,
  output logic status_out_b_o,
  output logic status_out_b_oe_n,
  output logic irq
);
  import cps_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------
  // time base
  // ----------------------------------------
  localparam int PRE_TICKS = MAX_TICKS / `CPS_PRE_DIV;
  localparam int FILT_TICKS = (MAX_TICKS / `CPS_FILT_DIV) < 1 ? 1 : MAX_TICKS / `CPS_FILT_DIV;
  logic [31:0] div_cnt;
  logic tick;
  // one tick feeds every timer so their ratios stay exact
  assign tick = (div_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_cnt <= 32'h0;
    else div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
  end

  // ----------------------------------------
  // threshold pin decode
  // ----------------------------------------
  logic pin_0v5_d;
  always_ff @(posedge clk or negedge rst_n) begin
    // zero after reset so a pin that is already low gives no false edge
    if (!rst_n) pin_0v5_d <= 1'b0;
    else pin_0v5_d <= pin_above_0v5;
  end
  wire pin_fall = pin_0v5_d & ~pin_above_0v5;
  wire term_mode = pin_floating | pin_above_0v8;
  cps_state_e state, next_state;
  wire dflt_sel = pin_floating | (~pin_above_0v8 & (state == CPS_PRE));
  wire above_pre = dflt_sel ? bat_above_pre_default : bat_above_pre_prog;

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [31:0] pre_t, max_t, filt_t;
  wire in_pre = (state == CPS_PRE);
  wire in_fast = (state == CPS_FAST) || (state == CPS_CV) || (state == CPS_DONE && !term_mode);
  wire pre_exp = (pre_t >= 32'(PRE_TICKS));
  wire max_exp = (max_t >= 32'(MAX_TICKS));
  wire filt_exp = (filt_t >= 32'(FILT_TICKS));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_t <= 32'h0;
      max_t <= 32'h0;
      filt_t <= 32'h0;
    end else begin
      pre_t <= (!in_pre || pin_fall) ? 32'h0 : pre_t + {31'h0, tick};
      max_t <= (!in_fast || pin_fall) ? 32'h0 : max_t + {31'h0, tick};
      filt_t <= (state != CPS_CV || !current_below_end) ? 32'h0 :
                filt_t + {31'h0, tick};
    end
  end

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CPS_IDLE: begin
        if (charge_enable) next_state = above_pre ? CPS_FAST : CPS_PRE;
      end
      CPS_PRE: begin
        if (pre_exp && !above_pre) next_state = CPS_FAULT;
        else if (above_pre) next_state = CPS_FAST;
      end
      CPS_FAST: begin
        if (max_exp) next_state = CPS_FAULT;
        else if (bat_near_regulation) next_state = CPS_CV;
      end
      CPS_CV: begin
        if (max_exp) next_state = CPS_FAULT;
        else if (filt_exp) next_state = CPS_DONE;
      end
      CPS_DONE: begin
        if (!term_mode && max_exp) next_state = CPS_FAULT;
        else if (term_mode && bat_below_recharge) next_state = CPS_FAST;
      end
      CPS_FAULT: next_state = CPS_FAULT;
      default: next_state = CPS_IDLE;
    endcase
    if (!charge_enable) next_state = CPS_IDLE;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= CPS_IDLE;
    else state <= next_state;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire charging = (state == CPS_PRE) || (state == CPS_FAST) || (state == CPS_CV) ||
                  (state == CPS_DONE && !term_mode);
  // pin low mode: done reported as fault, both lamps lit
  wire a_on = charging && !(state == CPS_DONE) || (state == CPS_FAULT) ||
              (state == CPS_DONE && !term_mode);
  wire b_on = (state == CPS_DONE) || (state == CPS_FAULT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_on <= 1'b0;
      precharge_current <= 1'b0;
      cv_mode <= 1'b0;
      use_default_threshold <= 1'b0;
      status_out_a_o <= 1'b0;
      status_out_a_oe_n <= `CPS_ST_OFF;
      status_out_b_o <= 1'b0;
      status_out_b_oe_n <= `CPS_ST_OFF;
    end else begin
      charge_on <= charging;
      // analog scales pre-charge to ten percent of fast current
      precharge_current <= (state == CPS_PRE);
      cv_mode <= (state == CPS_CV) || (state == CPS_DONE);
      use_default_threshold <= dflt_sel;
      status_out_a_o <= 1'b0;
      status_out_a_oe_n <= a_on ? `CPS_ST_ON : `CPS_ST_OFF;
      status_out_b_o <= 1'b0;
      status_out_b_oe_n <= b_on ? `CPS_ST_ON : `CPS_ST_OFF;
    end
  end

  // ----------------------------------------
  // registers: 0 status(read clears), 1 mask, 2 state
  // ----------------------------------------
  logic [3:0] ev_stat, ev_mask;
  wire [3:0] ev_in = {state != CPS_FAULT && next_state == CPS_FAULT,
                      state != CPS_DONE && next_state == CPS_DONE,
                      state != CPS_FAST && next_state == CPS_FAST,
                      pin_fall};
  wire rd_stat = rd && (addr == 4'h0);
  // set wins over the read clear
  wire [3:0] next_ev_stat = (rd_stat ? 4'h0 : ev_stat) | ev_in;
  wire [3:0] next_ev_mask = (wr && addr == 4'h1) ? wdata[3:0] : ev_mask;
  wire [31:0] rd_mux = (addr == 4'h0) ? {28'h0, ev_stat} :
                       (addr == 4'h1) ? {28'h0, ev_mask} :
                       (addr == 4'h2) ? {29'h0, state} : 32'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= 4'h0;
      ev_mask <= 4'h0;
      rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      ev_stat <= next_ev_stat;
      ev_mask <= next_ev_mask;
      rdata <= rd ? rd_mux : 32'h0;
      // irq follows the next status and mask so a mask write acts at once
      irq <= |(next_ev_stat & next_ev_mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_pre_stuck;
    state == CPS_PRE && pre_exp && !above_pre && charge_enable;
  endsequence
  sequence s_filter_done;
    state == CPS_CV && filt_exp && !max_exp && charge_enable;
  endsequence
  // the timers answer the falling edge of the pin, never a low level
  sequence s_pin_drop;
    rst_n && pin_above_0v5 ##1 !pin_above_0v5;
  endsequence
  chk_pre_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    s_pre_stuck |=> state == CPS_FAULT)
    else $error("pre-charge timeout did not fault");
  chk_skip_pre: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_IDLE && charge_enable && above_pre |=> state == CPS_FAST)
    else $error("pre-charge not skipped");
  chk_fast_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPS_FAST || state == CPS_CV) && max_exp && charge_enable
    |=> state == CPS_FAULT)
    else $error("max timer did not fault");
  chk_done_filter: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == CPS_DONE) && $past(state) == CPS_CV |-> $past(filt_exp))
    else $error("done without filter interval");
  chk_done_entry: assert property (@(posedge clk) disable iff (!rst_n)
    s_filter_done |=> state == CPS_DONE)
    else $error("done not entered after filter");
  chk_recharge: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_DONE && term_mode && bat_below_recharge && charge_enable
    |=> state == CPS_FAST)
    else $error("no recharge");
  chk_timer_clear: assert property (@(posedge clk) disable iff (!rst_n)
    pin_fall |=> pre_t == 32'h0 && max_t == 32'h0)
    else $error("edge did not clear timers");
  chk_edge_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_pin_drop |=> pre_t == 32'h0 && max_t == 32'h0)
    else $error("pin drop did not clear timers");
  chk_level_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    in_fast && !tick && !pin_above_0v5 && !pin_0v5_d |=> max_t == $past(max_t))
    else $error("low level cleared the max timer");
  chk_tick_only: assert property (@(posedge clk) disable iff (!rst_n)
    in_pre && !tick && !pin_fall |=> pre_t == $past(pre_t))
    else $error("pre timer moved without a tick");
  chk_pre_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_PRE && !above_pre && !pre_exp && charge_enable |=> state == CPS_PRE)
    else $error("left pre-charge early");
  chk_fast_entry: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_PRE && above_pre && charge_enable |=> state == CPS_FAST)
    else $error("threshold did not start fast charge");
  chk_cv_entry: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_FAST && bat_near_regulation && !max_exp && charge_enable
    |=> state == CPS_CV)
    else $error("constant voltage not entered");
  chk_pre_current: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_PRE |=> precharge_current)
    else $error("reduced current not selected");
  chk_float_default: assert property (@(posedge clk) disable iff (!rst_n)
    pin_floating |=> use_default_threshold)
    else $error("floating pin kept programmed threshold");
  chk_low_pin_default: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_PRE && !pin_above_0v8 |=> use_default_threshold)
    else $error("low pin in pre-charge kept programmed threshold");
  chk_charge_status: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPS_PRE || state == CPS_FAST || state == CPS_CV)
    |=> status_out_a_oe_n == `CPS_ST_ON && status_out_b_oe_n == `CPS_ST_OFF)
    else $error("charging status wrong");
  chk_standby_status: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_IDLE
    |=> status_out_a_oe_n == `CPS_ST_OFF && status_out_b_oe_n == `CPS_ST_OFF)
    else $error("standby status wrong");
  chk_status_done: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_DONE && term_mode |=> status_out_b_oe_n == `CPS_ST_ON
    && status_out_a_oe_n == `CPS_ST_OFF)
    else $error("done status wrong");
  chk_cont_charge: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_DONE && !term_mode |=> charge_on)
    else $error("charge stopped in fault mode");
  chk_term_stop: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_DONE && term_mode |=> !charge_on)
    else $error("charge not ended at end current");
  chk_fault_latch: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_FAULT && charge_enable |=> state == CPS_FAULT)
    else $error("fault released while enabled");
  chk_fault_stop: assert property (@(posedge clk) disable iff (!rst_n)
    state == CPS_FAULT |=> !charge_on)
    else $error("charging during fault");
endmodule

// [common/cps_params.svh]
// constants for the charge phase sequencer
// assumes a 20 MHz clk; time-base tick period is programmable at the top
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_CLK_PERIOD_NS 50
`define CPS_TICK_NS 1000000
`define CPS_TICK_CYCLES (`CPS_TICK_NS / `CPS_CLK_PERIOD_NS)
`define CPS_MAX_TICKS 6600
`define CPS_PRE_DIV 8
`define CPS_FILT_DIV 220
`define CPS_PRE_CURRENT_PCT 10
`define CPS_ST_ON 1'b0
`define CPS_ST_OFF 1'b1
`endif

// [common/cps_pkg.sv]
// types for the charge phase sequencer
// shared by the core and its bench
package cps_pkg;
  typedef enum logic [2:0] {
    CPS_IDLE = 3'b000,
    CPS_PRE = 3'b001,
    CPS_FAST = 3'b010,
    CPS_CV = 3'b011,
    CPS_DONE = 3'b100,
    CPS_FAULT = 3'b101
  } cps_state_e;
endpackage

// [testbench/cps_lamps.sv]
// lamp and host model on the two open-drain status pins
// assumes pull-ups to the lamp supply on both pins
`timescale 1ns/1ps
module cps_lamps (
  // pins from the core
  input wire logic a_o,
  input wire logic a_oe_n,
  input wire logic b_o,
  input wire logic b_oe_n,
  // lamps as the host sees them
  output logic lamp_a,
  output logic lamp_b
);
  // a released pin floats up through its pull-up, so its lamp stays dark
  assign lamp_a = a_oe_n ? 1'b0 : !a_o;
  assign lamp_b = b_oe_n ? 1'b0 : !b_o;
endmodule

// [testbench/tb_top.sv]
// bench for the charge phase sequencer, timers shortened to 4-cycle ticks
// assumes the lamp model on the status pins and one 20 MHz clock
`timescale 1ns/1ps
module tb_top;
  import cps_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b0, pre = 1'b0, near = 1'b0, rch = 1'b0, endc = 1'b0;
  logic flt = 1'b1, p08 = 1'b1, p05 = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic chg, prec, cv, dflt, ao, aoe, bo, boe, irq, la, lb;
  int failures = 0, check_count = 0;
  cps_sequencer #(.TICK_CYCLES(4), .MAX_TICKS(440)) dut (.clk(clk), .nrst(nrst),
    .charge_enable(en), .bat_above_pre_prog(pre), .bat_above_pre_default(pre),
    .bat_near_regulation(near), .bat_below_recharge(rch), .current_below_end(endc),
    .pin_floating(flt), .pin_above_0v8(p08), .pin_above_0v5(p05), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .charge_on(chg),
    .precharge_current(prec), .cv_mode(cv), .use_default_threshold(dflt),
    .status_out_a_o(ao), .status_out_a_oe_n(aoe), .status_out_b_o(bo),
    .status_out_b_oe_n(boe), .irq(irq));
  cps_lamps lamps (.a_o(ao), .a_oe_n(aoe), .b_o(bo), .b_oe_n(boe), .lamp_a(la), .lamp_b(lb));
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // bounded poll of the state register; running out ends the run
  task automatic wait_state(input cps_state_e s, input int bound);
    int n;
    n = 0;
    do begin
      reg_rd(4'h2);
      n++;
    end while (d !== {29'h0, s} && n < bound);
    check("state", d, {29'h0, s});
    if (d !== {29'h0, s}) test_done();
  endtask
  task automatic lamps_are(input logic [1:0] exp);
    check("lamps", {30'h0, la, lb}, {30'h0, exp});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    wait_state(CPS_IDLE, 1);
    lamps_are(2'b00);
    reg_rd(4'hF);
    check("unmapped", d, 32'h0);
    reg_wr(4'h1, 32'hF);
    reg_rd(4'h1);
    check("mask", d, 32'hF);
  endtask
  task automatic t_normal();
    en <= 1'b1;
    wait_state(CPS_PRE, 5);
    check("pre_i", {31'h0, prec}, 32'h1);
    check("dflt", {31'h0, dflt}, 32'h1);
    lamps_are(2'b10);
    pre <= 1'b1;
    wait_state(CPS_FAST, 5);
    check("pre_i", {31'h0, prec}, 32'h0);
    check("irq", {31'h0, irq}, 32'h1);
    reg_rd(4'h0);
    check("fast_ev", {31'h0, d[1]}, 32'h1);
    reg_rd(4'h2);
    check("irq", {31'h0, irq}, 32'h0);
    near <= 1'b1;
    wait_state(CPS_CV, 5);
    check("cv", {31'h0, cv}, 32'h1);
    endc <= 1'b1;
    wait_state(CPS_CV, 1);
    wait_state(CPS_DONE, 20);
    lamps_are(2'b01);
    check("chg", {31'h0, chg}, 32'h0);
    near <= 1'b0;
    endc <= 1'b0;
    rch <= 1'b1;
    wait_state(CPS_FAST, 5);
    rch <= 1'b0;
  endtask
  // a pin fall part way through restarts the fast timer, then it expires
  task automatic t_timer();
    repeat (1200) @(posedge clk);
    p05 <= 1'b0;
    repeat (1200) @(posedge clk);
    wait_state(CPS_FAST, 1);
    p05 <= 1'b1;
    wait_state(CPS_FAULT, 1000);
    reg_rd(4'h0);
    check("fall_ev", {31'h0, d[0]}, 32'h1);
    en <= 1'b0;
    wait_state(CPS_IDLE, 5);
  endtask
  task automatic t_pre_timeout();
    pre <= 1'b0;
    flt <= 1'b0;
    p08 <= 1'b0;
    en <= 1'b1;
    repeat (100) @(posedge clk);
    wait_state(CPS_PRE, 1);
    check("dflt", {31'h0, dflt}, 32'h1);
    wait_state(CPS_FAULT, 200);
    check("chg", {31'h0, chg}, 32'h0);
    en <= 1'b0;
    wait_state(CPS_IDLE, 5);
    lamps_are(2'b00);
  endtask
  // low pin: end current shows a fault but charging runs on to the max timer
  task automatic t_skip_lowpin();
    pre <= 1'b1;
    en <= 1'b1;
    wait_state(CPS_FAST, 1);
    near <= 1'b1;
    endc <= 1'b1;
    wait_state(CPS_DONE, 20);
    check("chg", {31'h0, chg}, 32'h1);
    lamps_are(2'b11);
    wait_state(CPS_FAULT, 1000);
    check("chg", {31'h0, chg}, 32'h0);
    reg_rd(4'h0);
    check("events", d, 32'hE);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_normal();
    t_timer();
    t_pre_timeout();
    t_skip_lowpin();
    test_done();
  end
endmodule
